// ---- verilog/timer_pkg.sv ----
// shared constants, encodings and range helpers for the delay timer core
package timer_pkg;
  // time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIME_BASE_NS = 1000000;
  localparam int TICK_CYCLES = TIME_BASE_NS / CLK_PERIOD_NS;
  localparam int FILTER_WIDE_MS = 20;
  localparam int FILTER_NARROW_MS = 1;
  localparam int BLINK_MS = 500;
  localparam int SV_W = 14;

  // register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_SET1 = 8'h04;
  localparam logic [7:0] ADDR_SET2 = 8'h08;
  localparam logic [7:0] ADDR_PRESENT = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_KEY = 8'h14;

  // config fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_DOWN_BIT = 4;
  localparam int CFG_NARROW_BIT = 5;
  localparam int CFG_TWIN_BIT = 6;
  localparam int CFG_FLICK_ON_BIT = 7;
  localparam int CFG_RANGE_LSB = 8;

  // status fields
  localparam int ST_OUT_BIT = 0;
  localparam int ST_RST_LED_BIT = 1;
  localparam int ST_UNIT_LED_BIT = 2;
  localparam int ST_RUN_BIT = 3;
  localparam int ST_GATE_BIT = 4;
  localparam int ST_PHASE_BIT = 5;
  localparam int ST_DONE_BIT = 6;
  localparam int KEY_RESET_BIT = 0;

  localparam logic [SV_W-1:0] SET1_RST = 14'h000a;
  localparam logic [SV_W-1:0] SET2_RST = 14'h000a;

  typedef enum logic [3:0] {
    M_A, M_A1, M_A2, M_A3, M_B, M_B1, M_D, M_E, M_F, M_Z
  } mode_e;

  typedef enum logic [3:0] {
    R_1MS, R_10MS, R_100MS, R_1S, R_MMSS, R_01MIN, R_1MIN, R_HHMM, R_01H, R_1H
  } range_e;

  localparam mode_e MODE_RST = M_A;
  localparam range_e RANGE_RST = R_1S;

  // milliseconds per count of the present value
  function automatic logic [21:0] unit_ms(range_e r);
    case (r)
      R_1MS: unit_ms = 22'h1;
      R_10MS: unit_ms = 22'ha;
      R_100MS: unit_ms = 22'h64;
      R_1S, R_MMSS: unit_ms = 22'h3e8;
      R_01MIN: unit_ms = 22'h1770;
      R_1MIN, R_HHMM: unit_ms = 22'hea60;
      R_01H: unit_ms = 22'h57e40;
      R_1H: unit_ms = 22'h36ee80;
      default: unit_ms = 22'h3e8;
    endcase
  endfunction : unit_ms

  // coarse ranges show timing by a flashing unit lamp
  function automatic logic coarse_range(range_e r);
    case (r)
      R_1MIN, R_HHMM, R_01H, R_1H: coarse_range = 1'b1;
      default: coarse_range = 1'b0;
    endcase
  endfunction : coarse_range
endpackage : timer_pkg

// ---- verilog/ms_tick.sv ----
// divider making the one-millisecond time base strobe
`timescale 1ns/1ns
module ms_tick #(
  parameter int unsigned DIV = 100000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule : ms_tick

// ---- verilog/chatter_filter.sv ----
// input filter: level must hold for the chosen width before it is accepted
`timescale 1ns/1ns
module chatter_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic narrow,
  input wire logic din,
  output logic dout
);
  logic [4:0] cnt_r;
  logic [4:0] thr;

  assign thr = narrow ? 5'(timer_pkg::FILTER_NARROW_MS) : 5'(timer_pkg::FILTER_WIDE_MS);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_r <= '0;
    end else if (tick) begin
      if (cnt_r + 5'h1 >= thr) begin
        dout <= din;
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 5'h1;
      end
    end
  end
endmodule : chatter_filter

// ---- verilog/delay_timer.sv ----
// programmable delay timer core with APB register access
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
module delay_timer #(
  parameter int unsigned TICK_DIV = timer_pkg::TICK_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic START_IN,
  input wire logic RESET_IN,
  input wire logic GATE_IN,
  output logic CTRL_OUT,
  output logic RST_LED,
  output logic UNIT_LED
);
  localparam int SW = timer_pkg::SV_W;

  // configuration
  timer_pkg::mode_e mode_r;
  timer_pkg::range_e range_r;
  logic down_r;
  logic narrow_r;
  logic twin_r;
  logic flick_on_r;
  logic [SW-1:0] set1_r;
  logic [SW-1:0] set2_r;
  logic key_r;

  // timing state
  logic [SW-1:0] pv_r;
  logic [21:0] pre_r;
  logic run_r;
  logic out_r;
  logic done_r;
  logic phase_r;
  logic start_q_r;
  logic blink_r;
  logic [8:0] blink_cnt_r;
  logic rst_led_r;
  logic unit_led_r;

  // bus
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  logic tick;
  logic start_f;
  logic reset_f;
  logic gate_f;

  ms_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk(REF_CLK),
    .rst(RST),
    .tick(tick)
  );

  chatter_filter u_start_filt (
    .clk(REF_CLK),
    .rst(RST),
    .tick(tick),
    .narrow(narrow_r),
    .din(START_IN),
    .dout(start_f)
  );

  chatter_filter u_reset_filt (
    .clk(REF_CLK),
    .rst(RST),
    .tick(tick),
    .narrow(narrow_r),
    .din(RESET_IN),
    .dout(reset_f)
  );

  chatter_filter u_gate_filt (
    .clk(REF_CLK),
    .rst(RST),
    .tick(tick),
    .narrow(narrow_r),
    .din(GATE_IN),
    .dout(gate_f)
  );

  // derived control terms
  logic flicker;
  logic init_phase;
  logic [SW-1:0] sv_cur;
  logic [SW-1:0] sv_init;
  logic [SW-1:0] sv_other;
  logic [SW-1:0] load_init;
  logic [SW-1:0] load_other;
  logic reach;
  logic [21:0] unit_last;
  logic adv;
  logic rst_hold;
  logic start_rise;
  logic start_fall;

  always_comb begin
    flicker = twin_r || mode_r == timer_pkg::M_B || mode_r == timer_pkg::M_B1
      || mode_r == timer_pkg::M_Z;
    if (twin_r) begin
      init_phase = flick_on_r;
    end else begin
      init_phase = (mode_r == timer_pkg::M_B1);
    end
    // phase high is the output-on interval and uses the second set value
    sv_cur = (flicker && phase_r) ? set2_r : set1_r;
    sv_other = phase_r ? set1_r : set2_r;
    sv_init = (flicker && init_phase) ? set2_r : set1_r;
    load_init = down_r ? sv_init : '0;
    load_other = down_r ? sv_other : '0;
    reach = down_r ? (pv_r == '0) : (pv_r >= sv_cur);
  end

  // every range from 1 ms to 1 h per count is open in both timer kinds
  assign unit_last = timer_pkg::unit_ms(range_r) - 22'h1;
  // reset input and reset key share one path
  assign rst_hold = reset_f | key_r;
  assign start_rise = start_f & ~start_q_r;
  assign start_fall = ~start_f & start_q_r;
  assign adv = tick & run_r & ~gate_f & ~reach;

  // start edge history runs through reset so a held start is no new edge
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      start_q_r <= 1'b0;
    end else begin
      start_q_r <= start_f;
    end
  end

  // timing engine
  always_ff @(posedge REF_CLK) begin
    if (RST || rst_hold) begin
      pv_r <= load_init;
      out_r <= 1'b0;
      run_r <= 1'b0;
      done_r <= 1'b0;
      phase_r <= init_phase;
      pre_r <= '0;
    end else begin
      if (adv) begin
        if (pre_r >= unit_last) begin
          pre_r <= '0;
          pv_r <= down_r ? pv_r - 1'b1 : pv_r + 1'b1;
        end else begin
          pre_r <= pre_r + 22'h1;
        end
      end
      if (flicker) begin
        if (start_rise && !run_r) begin
          run_r <= 1'b1;
          phase_r <= init_phase;
          out_r <= init_phase;
          pv_r <= load_init;
          pre_r <= '0;
        end else if (run_r && reach) begin
          phase_r <= ~phase_r;
          out_r <= ~phase_r;
          pv_r <= load_other;
          pre_r <= '0;
        end
      end else begin
        case (mode_r)
          timer_pkg::M_A2, timer_pkg::M_A3: begin
            if (run_r && reach) begin
              out_r <= 1'b1;
              run_r <= 1'b0;
              done_r <= 1'b1;
            end else begin
              // times from power-on or reset release; start holds it off
              run_r <= ~start_f & ~done_r;
            end
          end
          timer_pkg::M_D: begin
            if (start_rise) begin
              out_r <= 1'b1;
              run_r <= 1'b0;
              pv_r <= load_init;
              pre_r <= '0;
            end else if (start_fall) begin
              run_r <= 1'b1;
            end else if (run_r && reach) begin
              out_r <= 1'b0;
              run_r <= 1'b0;
            end
          end
          timer_pkg::M_E: begin
            if (start_rise) begin
              out_r <= 1'b1;
              run_r <= 1'b1;
              pv_r <= load_init;
              pre_r <= '0;
            end else if (run_r && reach) begin
              out_r <= 1'b0;
              run_r <= 1'b0;
            end
          end
          timer_pkg::M_F: begin
            if (run_r && reach) begin
              out_r <= 1'b1;
              run_r <= 1'b0;
              done_r <= 1'b1;
            end else begin
              // accumulates only while start is held
              run_r <= start_f & ~done_r;
            end
          end
          default: begin
            if (run_r && reach) begin
              out_r <= 1'b1;
              run_r <= 1'b0;
              done_r <= 1'b1;
            end else if (start_rise && !done_r) begin
              run_r <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // unit lamp blink base, half period in milliseconds
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
    end else if (tick) begin
      if (blink_cnt_r == 9'(timer_pkg::BLINK_MS - 1)) begin
        blink_cnt_r <= '0;
        blink_r <= ~blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 9'h1;
      end
    end
  end

  // lamps
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rst_led_r <= 1'b0;
      unit_led_r <= 1'b1;
    end else begin
      rst_led_r <= reset_f;
      if (timer_pkg::coarse_range(range_r) && run_r && !gate_f) begin
        unit_led_r <= blink_r;
      end else begin
        unit_led_r <= 1'b1;
      end
    end
  end

  // apb: one wait state; data is formed in the first access cycle
  logic acc_first;
  logic take;
  logic addr_ok;

  assign acc_first = PSEL & PENABLE & ~pready_r;
  assign take = PSEL & PENABLE & pready_r;

  always_comb begin
    case (PADDR)
      timer_pkg::ADDR_CONFIG, timer_pkg::ADDR_SET1, timer_pkg::ADDR_SET2,
      timer_pkg::ADDR_PRESENT, timer_pkg::ADDR_STATUS, timer_pkg::ADDR_KEY: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= acc_first;
      if (acc_first) begin
        pslverr_r <= ~addr_ok;
        prdata_r <= '0;
        if (!PWRITE) begin
          case (PADDR)
            timer_pkg::ADDR_CONFIG: begin
              prdata_r[timer_pkg::CFG_MODE_LSB +: 4] <= mode_r;
              prdata_r[timer_pkg::CFG_DOWN_BIT] <= down_r;
              prdata_r[timer_pkg::CFG_NARROW_BIT] <= narrow_r;
              prdata_r[timer_pkg::CFG_TWIN_BIT] <= twin_r;
              prdata_r[timer_pkg::CFG_FLICK_ON_BIT] <= flick_on_r;
              prdata_r[timer_pkg::CFG_RANGE_LSB +: 4] <= range_r;
            end
            timer_pkg::ADDR_SET1: prdata_r[SW-1:0] <= set1_r;
            timer_pkg::ADDR_SET2: prdata_r[SW-1:0] <= set2_r;
            timer_pkg::ADDR_PRESENT: prdata_r[SW-1:0] <= pv_r;
            timer_pkg::ADDR_STATUS: begin
              prdata_r[timer_pkg::ST_OUT_BIT] <= out_r;
              prdata_r[timer_pkg::ST_RST_LED_BIT] <= rst_led_r;
              prdata_r[timer_pkg::ST_UNIT_LED_BIT] <= unit_led_r;
              prdata_r[timer_pkg::ST_RUN_BIT] <= run_r;
              prdata_r[timer_pkg::ST_GATE_BIT] <= gate_f;
              prdata_r[timer_pkg::ST_PHASE_BIT] <= phase_r;
              prdata_r[timer_pkg::ST_DONE_BIT] <= done_r;
            end
            default: prdata_r <= '0;
          endcase
        end
      end
    end
  end

  // register writes take effect at the completing edge only
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      mode_r <= timer_pkg::MODE_RST;
      range_r <= timer_pkg::RANGE_RST;
      down_r <= 1'b0;
      narrow_r <= 1'b0;
      twin_r <= 1'b0;
      flick_on_r <= 1'b0;
      set1_r <= timer_pkg::SET1_RST;
      set2_r <= timer_pkg::SET2_RST;
    end else if (take && PWRITE) begin
      case (PADDR)
        timer_pkg::ADDR_CONFIG: begin
          mode_r <= timer_pkg::mode_e'(PWDATA[timer_pkg::CFG_MODE_LSB +: 4]);
          down_r <= PWDATA[timer_pkg::CFG_DOWN_BIT];
          narrow_r <= PWDATA[timer_pkg::CFG_NARROW_BIT];
          twin_r <= PWDATA[timer_pkg::CFG_TWIN_BIT];
          flick_on_r <= PWDATA[timer_pkg::CFG_FLICK_ON_BIT];
          range_r <= timer_pkg::range_e'(PWDATA[timer_pkg::CFG_RANGE_LSB +: 4]);
        end
        timer_pkg::ADDR_SET1: set1_r <= PWDATA[SW-1:0];
        timer_pkg::ADDR_SET2: set2_r <= PWDATA[SW-1:0];
        default: ;
      endcase
    end
  end

  // front reset key: one-cycle press from a register write
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      key_r <= 1'b0;
    end else begin
      key_r <= take & PWRITE & (PADDR == timer_pkg::ADDR_KEY)
        & PWDATA[timer_pkg::KEY_RESET_BIT];
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign CTRL_OUT = out_r;
  assign RST_LED = rst_led_r;
  assign UNIT_LED = unit_led_r;
endmodule : delay_timer

// ---- tb/delay_timer_props.sv ----
// concurrent checks on the delay timer core ports
`timescale 1ns/1ns
module delay_timer_props (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic START_IN,
  input wire logic RESET_IN,
  input wire logic GATE_IN,
  input wire logic CTRL_OUT,
  input wire logic RST_LED,
  input wire logic UNIT_LED
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // bus handshake: one wait state, one-cycle ready
  a_ready_wait: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
    else $error("ready not in second access cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_ready_sel: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("ready outside an access phase");
  a_err_zero: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
    else $error("error answer carries data");
  a_upper_zero: assert property (PREADY |-> PRDATA[31:14] == 18'h0)
    else $error("upper read bits not zero");
  a_reset_vals: assert property ($fell(RST) |-> !CTRL_OUT && !RST_LED && UNIT_LED)
    else $error("outputs wrong after reset release");
  a_led_pin: assert property ($rose(RST_LED) |-> $past(RESET_IN) && $past(RESET_IN, 2))
    else $error("reset lamp lit without reset pin");
  a_led_off: assert property ($fell(RST_LED) |-> !$past(RESET_IN, 2))
    else $error("reset lamp dark while reset pin held");
  a_out_held_off: assert property (RST_LED && $past(RST_LED, 2) |-> !CTRL_OUT)
    else $error("output on during timer reset");
  a_out_rise: assert property ($rose(CTRL_OUT) |-> !RST_LED && !$past(RST_LED))
    else $error("output rose during timer reset");
endmodule : delay_timer_props

bind delay_timer delay_timer_props chk (.REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .START_IN, .RESET_IN, .GATE_IN, .CTRL_OUT,
  .RST_LED, .UNIT_LED);

// ---- tb/field_contacts.sv ----
// field contact model: drives one input pin, with optional bounce on each change
`timescale 1ns/1ns
module field_contacts (
  input wire logic clk,
  input wire logic want,
  input wire logic chatter,
  output logic pin
);
  logic last_r = 1'b0;
  logic pin_r = 1'b0;
  int bounce_r = 0;
  assign pin = pin_r;
  // bounce toggles every cycle so a filter cannot settle on it early
  always @(posedge clk) begin
    last_r <= want;
    if (want != last_r && chatter) begin
      bounce_r <= 7;
    end else if (bounce_r > 0) begin
      bounce_r <= bounce_r - 1;
    end
    pin_r <= (bounce_r > 0) ? ~pin_r : want;
  end
endmodule : field_contacts

// ---- tb/delay_timer_tb.sv ----
// self-checking bench for the delay timer core
`timescale 1ns/1ns
module delay_timer_tb;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, START_IN, RESET_IN, GATE_IN, CTRL_OUT, RST_LED, UNIT_LED;
  logic want_start = 1'b0;
  logic want_reset = 1'b0;
  logic want_gate = 1'b0;
  logic chatter = 1'b0;
  logic [31:0] rd, rd2;
  logic err, prev_led;
  int bad_count = 0;
  int total_checks = 0;
  int flips;

  // ten cycles per tick keeps a 20 ms filter at 200 cycles
  delay_timer #(.TICK_DIV(10)) uut (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .START_IN(START_IN), .RESET_IN(RESET_IN),
    .GATE_IN(GATE_IN), .CTRL_OUT(CTRL_OUT), .RST_LED(RST_LED), .UNIT_LED(UNIT_LED));
  field_contacts c_start (.clk(REF_CLK), .want(want_start), .chatter(chatter), .pin(START_IN));
  field_contacts c_reset (.clk(REF_CLK), .want(want_reset), .chatter(chatter), .pin(RESET_IN));
  field_contacts c_gate (.clk(REF_CLK), .want(want_gate), .chatter(chatter), .pin(GATE_IN));

  initial begin
    forever #5 REF_CLK = ~REF_CLK;
  end

  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic timeout();
    bad_count++;
    $display("mismatch at %0t: wait ran out", $time);
    print_verdict();
  endtask : timeout

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (n >= 16) timeout();
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wait_out(input logic v);
    int n;
    n = 0;
    while (CTRL_OUT !== v && n < 3000) begin
      @(posedge REF_CLK);
      n++;
    end
    if (n >= 3000) timeout();
  endtask : wait_out

  task automatic wait_run();
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[3] !== 1'b1 && n < 200) begin
      apb(1'b0, timer_pkg::ADDR_STATUS, 32'h0);
      n++;
    end
    if (n >= 200) timeout();
  endtask : wait_run

  task automatic pulse_start(input int len);
    want_start <= 1'b1;
    cyc(len);
    want_start <= 1'b0;
  endtask : pulse_start

  task automatic setup(input logic [31:0] cfg, input logic [31:0] s1);
    apb(1'b1, timer_pkg::ADDR_SET1, s1);
    apb(1'b1, timer_pkg::ADDR_CONFIG, cfg);
    apb(1'b1, timer_pkg::ADDR_KEY, 32'h1);
    cyc(3);
  endtask : setup

  initial begin
    cyc(2);
    RST <= 1'b0;
    apb(1'b0, timer_pkg::ADDR_CONFIG, 32'h0);
    check(rd, 32'h300, "config default");
    apb(1'b0, timer_pkg::ADDR_SET1, 32'h0);
    check(rd, 32'ha, "set1 default");
    apb(1'b0, 8'h18, 32'h0);
    check({rd[31:1], err}, 32'h1, "unmapped read");
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, timer_pkg::ADDR_CONFIG, {20'h0, i[3:0], 1'b0, i[0], 2'b0, i[3:0]});
      apb(1'b0, timer_pkg::ADDR_CONFIG, 32'h0);
      check(rd, {20'h0, i[3:0], 1'b0, i[0], 2'b0, i[3:0]}, "config field");
    end
    setup(32'h20, 32'h3);
    pulse_start(20);
    wait_out(1'b1);
    check({31'h0, UNIT_LED}, 32'h1, "unit lamp steady");
    apb(1'b1, timer_pkg::ADDR_KEY, 32'h1);
    cyc(3);
    check({31'h0, CTRL_OUT}, 32'h0, "key clears output");
    apb(1'b0, timer_pkg::ADDR_PRESENT, 32'h0);
    check(rd, 32'h0, "key clears value");
    pulse_start(20);
    wait_out(1'b1);
    want_reset <= 1'b1;
    cyc(30);
    check({31'h0, RST_LED}, 32'h1, "reset lamp");
    check({31'h0, CTRL_OUT}, 32'h0, "output off in reset");
    apb(1'b0, timer_pkg::ADDR_PRESENT, 32'h0);
    check(rd, 32'h0, "up reset value");
    pulse_start(20);
    cyc(40);
    apb(1'b0, timer_pkg::ADDR_STATUS, 32'h0);
    check({30'h0, rd[3], CTRL_OUT}, 32'h0, "start ignored in reset");
    want_reset <= 1'b0;
    cyc(30);
    check({31'h0, RST_LED}, 32'h0, "reset lamp off");
    setup(32'h30, 32'h5);
    pulse_start(20);
    wait_run();
    cyc(15);
    want_reset <= 1'b1;
    cyc(20);
    apb(1'b0, timer_pkg::ADDR_PRESENT, 32'h0);
    check(rd, 32'h5, "down reset reloads");
    want_reset <= 1'b0;
    cyc(20);
    pulse_start(20);
    wait_out(1'b1);
    apb(1'b0, timer_pkg::ADDR_PRESENT, 32'h0);
    check(rd, 32'h0, "down reaches zero");
    setup(32'h20, 32'hc8);
    pulse_start(20);
    wait_run();
    want_gate <= 1'b1;
    cyc(20);
    apb(1'b0, timer_pkg::ADDR_PRESENT, 32'h0);
    rd2 = rd;
    cyc(100);
    apb(1'b0, timer_pkg::ADDR_PRESENT, 32'h0);
    check(rd, rd2, "gate freezes value");
    want_gate <= 1'b0;
    cyc(40);
    apb(1'b0, timer_pkg::ADDR_PRESENT, 32'h0);
    check({31'h0, rd > rd2}, 32'h1, "count resumes");
    want_start <= 1'b1;
    setup(32'h22, 32'h1e);
    cyc(20);
    apb(1'b0, timer_pkg::ADDR_PRESENT, 32'h0);
    rd2 = rd;
    cyc(100);
    apb(1'b0, timer_pkg::ADDR_PRESENT, 32'h0);
    check({rd[30:0], CTRL_OUT}, {rd2[30:0], 1'b0}, "start stops timing");
    want_start <= 1'b0;
    wait_out(1'b1);
    // accumulate mode: a short start leaves the count short of the set value
    setup(32'h28, 32'h5);
    pulse_start(20);
    cyc(100);
    check({31'h0, CTRL_OUT}, 32'h0, "accumulate stops with start");
    pulse_start(100);
    wait_out(1'b1);
    // signal-off and interval modes: output on at the start edge, off at the set value
    for (int m = 6; m < 8; m++) begin
      setup({24'h0, 4'h2, m[3:0]}, 32'h5);
      pulse_start(20);
      check({31'h0, CTRL_OUT}, 32'h1, "output on at start");
      wait_out(1'b0);
    end
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, timer_pkg::ADDR_SET2, 32'h4);
      setup({24'h0, f[0], 7'h64}, 32'h4);
      pulse_start(20);
      wait_run();
      check({31'h0, CTRL_OUT}, {31'h0, f[0]}, "flicker first phase");
      wait_out(~f[0]);
    end
    chatter <= 1'b1;
    // set value long enough that the run bit is still up when polled
    setup(32'h0, 32'h64);
    pulse_start(100);
    cyc(300);
    apb(1'b0, timer_pkg::ADDR_STATUS, 32'h0);
    check({31'h0, rd[3]}, 32'h0, "short pulse refused");
    pulse_start(300);
    wait_run();
    chatter <= 1'b0;
    setup(32'h620, 32'h64);
    pulse_start(20);
    wait_run();
    flips = 0;
    prev_led = UNIT_LED;
    repeat (12000) begin
      @(posedge REF_CLK);
      if (UNIT_LED !== prev_led) flips++;
      prev_led = UNIT_LED;
    end
    check({31'h0, flips >= 2}, 32'h1, "unit lamp flashes");
    // second reset in mid-run: configuration and lamps return to defaults
    RST <= 1'b1;
    cyc(2);
    RST <= 1'b0;
    apb(1'b0, timer_pkg::ADDR_CONFIG, 32'h0);
    check(rd, 32'h300, "config after reset");
    check({31'h0, UNIT_LED}, 32'h1, "unit lamp after reset");
    print_verdict();
  end
endmodule : delay_timer_tb
